/* rtl/rsic_pkg.sv */
// Purpose: shared constants and carriers for the reset status and interrupt controller
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: all offsets are byte addresses
package rsic_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [31:0] RSIC_OFS_STATUS = 32'h0000_0000;
    localparam logic [31:0] RSIC_OFS_FLAG = 32'h0000_0004;
    localparam logic [31:0] RSIC_OFS_MASK = 32'h0000_0008;
    localparam logic [31:0] RSIC_OFS_PORT = 32'h0000_000C;
    localparam logic [31:0] RSIC_OFS_CTRL = 32'h0000_0010;
    localparam int RSIC_IDX_LSB = 2;
    localparam int RSIC_IDX_MSB = 4;
    localparam logic [31:0] RSIC_MAP_LIMIT = 32'h0000_0014;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RSIC_ST_GIE = 0;
    localparam int RSIC_ST_SLEEP = 1;
    localparam int RSIC_ST_PD = 3;
    localparam int RSIC_ST_WDT = 4;
    localparam int RSIC_ST_WAKE = 7;
    localparam int RSIC_FL_TMR = 0;
    localparam int RSIC_FL_PCHG = 1;
    localparam int RSIC_FL_EXT = 2;
    localparam int RSIC_CTRL_EXTSEL = 0;
    localparam int RSIC_NSRC = 3;
    localparam int RSIC_PORTW = 8;

    // ------------------------------------------------------------
    // reset values and vectors
    // ------------------------------------------------------------
    localparam logic RSIC_POR_WAKE = 1'b0;
    localparam logic RSIC_POR_WDT = 1'b1;
    localparam logic RSIC_POR_PD = 1'b1;
    localparam logic [2:0] RSIC_RST_FLAGS = 3'h0;
    localparam logic [2:0] RSIC_RST_MASK = 3'h0;
    localparam logic [7:0] RSIC_PIN_IDLE = 8'hFF;
    localparam logic [7:0] RSIC_EXT_BIT = 8'h01;
    localparam logic [11:0] RSIC_VEC_IRQ = 12'h008;
    localparam logic [11:0] RSIC_VEC_TRAP = 12'h001;
    localparam logic [1:0] RSIC_HTRANS_NONSEQ = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RSIC_RUN = 2'h0,
        RSIC_SLEEP = 2'h1,
        RSIC_HOLD = 2'h3
    } rsic_mode_e;

    // one-cycle strobes from the instruction sequencer
    typedef struct packed {
        logic watchdog_clear_instr;
        logic sleep_instr;
        logic global_irq_on_instr;
        logic global_irq_off_instr;
        logic return_from_isr_instr;
        logic trap_instr;
    } rsic_instr_s;

    // fetch steering towards the core
    typedef struct packed {
        logic core_reset;
        logic vec_req;
        logic [11:0] vec_addr;
        logic wake;
        logic irq;
        logic sleeping;
    } rsic_fetch_s;

endpackage

/* rtl/rsic_top.sv */
// Purpose: reset cause flags, interrupt flags, mask, global enable and vectoring
// Assumes: core_clk 200 MHz; sequencer strobes and watchdog pulse are core_clk synchronous
// Notes: pins (clear pin and general port) pass a three-stage synchroniser
//
// Contract
// - reset on power-on, clear-pin high-low-high pulse, or watchdog time-out.
// - power-on leaves wake flag 0, watchdog flag 1, power-down flag 1.
// - clear pin while running: wake flag 0, others unchanged.
// - clear pin waking from sleep: wake 0, watchdog 1, power-down 0.
// - watchdog time-out while running: wake 0, watchdog 0, power-down unchanged.
// - watchdog time-out waking from sleep: all three flags 0.
// - port-change wake: wake 1, watchdog 1, power-down 0.
// - watchdog-clear instruction sets watchdog and power-down flags, wake unchanged.
// - sleep instruction: watchdog 1, power-down 0, wake unchanged.
// - three interrupt sources: timer overflow, port change, external pin.
// - only input port pins count for change; bit zero excluded as interrupt pin.
// - enabled port change wakes sleep; continue in line or vector 008H.
// - each request has its own flag bit; separate software mask register.
// - enable instruction sets global enable, disable instruction clears it.
// - enabled interrupt makes next fetch come from 008H.
// - timer and external flags set regardless of mask; port-change flag is not.
// - request to core is AND of flags and mask.
// - return instruction ends routine and sets global enable.
// - enabled software trap makes next fetch come from 001H.
// - status bits: wake at 7, watchdog at 4, power-down at 3.
`timescale 1ns/1ps
module rsic_top (
    // clock and power-on reset
    input wire logic core_clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // pins
    input wire logic clear_n_pin,
    input wire logic [7:0] port6_pins,
    // port configuration from the port block, 1 marks an input pin
    input wire logic [7:0] port6_is_input,
    // events from timer and watchdog
    input wire logic timer_counter_ovf,
    input wire logic wdt_timeout,
    // instruction sequencer
    input wire rsic_pkg::rsic_instr_s instr,
    output rsic_pkg::rsic_fetch_s fetch
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        rsic_pkg::rsic_mode_e mode;
        logic wake_flag;
        logic wdt_flag;
        logic pd_flag;
        logic gie;
        logic [2:0] irq_flag_register;
        logic [2:0] irq_mask_register;
        logic ext_sel;
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic [8:0] sync3;
        logic [8:0] pin;
        logic [7:0] port_ref;
        rsic_pkg::rsic_fetch_s fetch;
        logic ap_wr;
        logic [2:0] ap_idx;
        logic rdy;
        logic resp;
        logic [31:0] rdata;
    } rsic_state_s;

    rsic_state_s state_reg;
    rsic_state_s state_next;

    // combinational helpers, also read by the assertions
    logic clr_fall;
    logic clr_rise;
    logic rst_evt;
    logic [7:0] chg_active;
    logic port_chg;
    logic ext_fall;
    logic ap_take;
    logic ap_mapped;
    logic [2:0] ap_idx_now;
    logic [2:0] irq_set;
    logic irq_req;
    logic [8:0] pin_filt;

    // ------------------------------------------------------------
    // pin filter: a change counts once stages two and three agree
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++) begin : g_filt
            assign pin_filt[gi] = (state_reg.sync2[gi] == state_reg.sync3[gi]) ?
                                  state_reg.sync3[gi] : state_reg.pin[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    function automatic logic [31:0] rsic_read(input rsic_state_s s, input logic [2:0] idx);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (idx)
            3'h0: begin
                w[rsic_pkg::RSIC_ST_GIE] = s.gie;
                w[rsic_pkg::RSIC_ST_SLEEP] = (s.mode == rsic_pkg::RSIC_SLEEP);
                w[rsic_pkg::RSIC_ST_PD] = s.pd_flag;
                w[rsic_pkg::RSIC_ST_WDT] = s.wdt_flag;
                w[rsic_pkg::RSIC_ST_WAKE] = s.wake_flag;
            end
            3'h1: w[2:0] = s.irq_flag_register;
            3'h2: w[2:0] = s.irq_mask_register;
            3'h3: w[7:0] = s.pin[7:0];
            3'h4: w[rsic_pkg::RSIC_CTRL_EXTSEL] = s.ext_sel;
            default: w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        // event decode from filtered pins
        clr_fall = state_reg.pin[8] & ~pin_filt[8];
        clr_rise = ~state_reg.pin[8] & pin_filt[8];
        rst_evt = clr_fall | wdt_timeout;
        // only input pins, minus bit zero when it serves as interrupt pin
        chg_active = port6_is_input & ~(state_reg.ext_sel ? rsic_pkg::RSIC_EXT_BIT : 8'h00);
        port_chg = |((pin_filt[7:0] ^ state_reg.port_ref) & chg_active);
        ext_fall = state_reg.ext_sel & state_reg.pin[0] & ~pin_filt[0];
        // bus address phase
        ap_take = hsel & hready & (htrans == rsic_pkg::RSIC_HTRANS_NONSEQ);
        ap_mapped = (haddr < rsic_pkg::RSIC_MAP_LIMIT);
        ap_idx_now = ap_mapped ? haddr[rsic_pkg::RSIC_IDX_MSB:rsic_pkg::RSIC_IDX_LSB] : 3'h7;
        // flag sources; port change only counts while its mask is on
        irq_set = 3'h0;
        irq_set[rsic_pkg::RSIC_FL_TMR] = timer_counter_ovf;
        irq_set[rsic_pkg::RSIC_FL_EXT] = ext_fall;
        irq_set[rsic_pkg::RSIC_FL_PCHG] = port_chg &
                                          state_reg.irq_mask_register[rsic_pkg::RSIC_FL_PCHG];
        irq_req = |(state_reg.irq_flag_register & state_reg.irq_mask_register);

        // synchroniser chain, first stage feeds only the second
        state_next.sync1 = {clear_n_pin, port6_pins};
        state_next.sync2 = state_reg.sync1;
        state_next.sync3 = state_reg.sync2;
        state_next.pin = pin_filt;

        // pulses and response default low, ready defaults high
        state_next.fetch.vec_req = 1'b0;
        state_next.fetch.wake = 1'b0;
        state_next.rdy = 1'b1;
        state_next.resp = 1'b0;

        // flags: hardware set beats a software write in the same cycle
        state_next.irq_flag_register = state_reg.irq_flag_register | irq_set;
        if (state_reg.ap_wr && state_reg.ap_idx == 3'h1) begin
            state_next.irq_flag_register = hwdata[2:0] | irq_set;
        end
        if (state_reg.ap_wr && state_reg.ap_idx == 3'h2) begin
            state_next.irq_mask_register = hwdata[2:0];
        end
        if (state_reg.ap_wr && state_reg.ap_idx == 3'h4) begin
            state_next.ext_sel = hwdata[rsic_pkg::RSIC_CTRL_EXTSEL];
        end

        // change reference follows the last read or the last seen change
        if (port_chg) begin
            state_next.port_ref = pin_filt[7:0];
        end

        // address phase capture; read data goes out in the data phase
        state_next.ap_wr = ap_take & hwrite & ap_mapped;
        state_next.ap_idx = ap_idx_now;
        state_next.rdata = 32'h0000_0000;
        if (ap_take && !hwrite) begin
            state_next.rdata = rsic_read(state_reg, ap_idx_now);
            if (ap_idx_now == 3'h3) begin
                state_next.port_ref = pin_filt[7:0];
            end
        end

        // instruction effects on flags and global enable
        if (instr.global_irq_on_instr || instr.return_from_isr_instr) begin
            state_next.gie = 1'b1;
        end
        if (instr.global_irq_off_instr) begin
            state_next.gie = 1'b0;
        end
        if (instr.watchdog_clear_instr) begin
            state_next.wdt_flag = 1'b1;
            state_next.pd_flag = 1'b1;
        end

        // vectoring: trap first since it comes from the instruction in hand
        if (instr.trap_instr && state_reg.gie) begin
            state_next.fetch.vec_req = 1'b1;
            state_next.fetch.vec_addr = rsic_pkg::RSIC_VEC_TRAP;
            state_next.gie = 1'b0;
        end else if (irq_req && state_reg.gie && state_reg.mode == rsic_pkg::RSIC_RUN) begin
            state_next.fetch.vec_req = 1'b1;
            state_next.fetch.vec_addr = rsic_pkg::RSIC_VEC_IRQ;
            state_next.gie = 1'b0;
        end

        // power mode machine
        case (state_reg.mode)
            rsic_pkg::RSIC_RUN: begin
                if (instr.sleep_instr) begin
                    state_next.mode = rsic_pkg::RSIC_SLEEP;
                    state_next.wdt_flag = 1'b1;
                    state_next.pd_flag = 1'b0;
                end
            end
            rsic_pkg::RSIC_SLEEP: begin
                // port change armed before sleep wakes the core
                if (port_chg && state_reg.irq_mask_register[rsic_pkg::RSIC_FL_PCHG]) begin
                    state_next.mode = rsic_pkg::RSIC_RUN;
                    state_next.fetch.wake = 1'b1;
                    state_next.wake_flag = 1'b1;
                    state_next.wdt_flag = 1'b1;
                    state_next.pd_flag = 1'b0;
                    if (state_reg.gie) begin
                        state_next.fetch.vec_req = 1'b1;
                        state_next.fetch.vec_addr = rsic_pkg::RSIC_VEC_IRQ;
                        state_next.gie = 1'b0;
                    end
                end
            end
            rsic_pkg::RSIC_HOLD: begin
                if (clr_rise) begin
                    state_next.mode = rsic_pkg::RSIC_RUN;
                end
            end
            default: state_next.mode = rsic_pkg::RSIC_RUN;
        endcase

        // reset events override the mode, flag, enable, mask and vector updates above
        if (wdt_timeout) begin
            state_next.wake_flag = 1'b0;
            state_next.wdt_flag = 1'b0;
            state_next.pd_flag = (state_reg.mode == rsic_pkg::RSIC_SLEEP) ? 1'b0 : state_reg.pd_flag;
            // a time-out inside a pin reset must not end that reset early
            if (state_reg.mode != rsic_pkg::RSIC_HOLD) begin
                state_next.mode = rsic_pkg::RSIC_RUN;
            end
        end
        if (clr_fall) begin
            // clear pin wins over a same-cycle time-out or instruction
            state_next.wake_flag = 1'b0;
            state_next.wdt_flag = state_reg.wdt_flag;
            state_next.pd_flag = state_reg.pd_flag;
            if (state_reg.mode == rsic_pkg::RSIC_SLEEP) begin
                state_next.wdt_flag = 1'b1;
                state_next.pd_flag = 1'b0;
            end
            state_next.mode = rsic_pkg::RSIC_HOLD;
        end
        if (rst_evt) begin
            // interrupt state returns to its reset values with the core
            state_next.gie = 1'b0;
            state_next.irq_flag_register = rsic_pkg::RSIC_RST_FLAGS;
            state_next.irq_mask_register = rsic_pkg::RSIC_RST_MASK;
            state_next.ext_sel = 1'b0;
            state_next.fetch.vec_req = 1'b0;
            state_next.fetch.wake = 1'b0;
        end

        // outputs to the core
        state_next.fetch.core_reset = rst_evt | (state_next.mode == rsic_pkg::RSIC_HOLD);
        state_next.fetch.irq = |(state_next.irq_flag_register & state_next.irq_mask_register);
        state_next.fetch.sleeping = (state_next.mode == rsic_pkg::RSIC_SLEEP);
    end

    // ------------------------------------------------------------
    // state register; power-on takes constants only
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
            state_reg.mode <= rsic_pkg::RSIC_RUN;
            state_reg.wake_flag <= rsic_pkg::RSIC_POR_WAKE;
            state_reg.wdt_flag <= rsic_pkg::RSIC_POR_WDT;
            state_reg.pd_flag <= rsic_pkg::RSIC_POR_PD;
            state_reg.sync1 <= {1'b1, rsic_pkg::RSIC_PIN_IDLE};
            state_reg.sync2 <= {1'b1, rsic_pkg::RSIC_PIN_IDLE};
            state_reg.sync3 <= {1'b1, rsic_pkg::RSIC_PIN_IDLE};
            state_reg.pin <= {1'b1, rsic_pkg::RSIC_PIN_IDLE};
            state_reg.port_ref <= rsic_pkg::RSIC_PIN_IDLE;
            state_reg.fetch.core_reset <= 1'b1;
            state_reg.rdy <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops
    assign hreadyout = state_reg.rdy;
    assign hrdata = state_reg.rdata;
    assign hresp = state_reg.resp;
    assign fetch = state_reg.fetch;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    sequence s_quiet;
        !rst_evt && !instr.trap_instr;
    endsequence

    sequence s_irq_pending;
        state_reg.gie && irq_req && state_reg.mode == rsic_pkg::RSIC_RUN;
    endsequence

    sequence s_port_wake;
        state_reg.mode == rsic_pkg::RSIC_SLEEP && port_chg
        && state_reg.irq_mask_register[rsic_pkg::RSIC_FL_PCHG];
    endsequence

    AST_WDT_RESET: assert property (wdt_timeout |=> fetch.core_reset)
        else $error("watchdog time-out did not reset the core");
    AST_WDT_RUN: assert property (wdt_timeout && !clr_fall && state_reg.mode == rsic_pkg::RSIC_RUN
        |=> !state_reg.wake_flag && !state_reg.wdt_flag && state_reg.pd_flag == $past(state_reg.pd_flag))
        else $error("watchdog flags wrong after run time-out");
    AST_WDT_SLEEP: assert property (wdt_timeout && !clr_fall && state_reg.mode == rsic_pkg::RSIC_SLEEP
        |=> !state_reg.wake_flag && !state_reg.wdt_flag && !state_reg.pd_flag)
        else $error("watchdog flags wrong after sleep time-out");
    AST_WATCHDOG_CLEAR_INSTR: assert property (instr.watchdog_clear_instr && !rst_evt
        |=> state_reg.wdt_flag && state_reg.pd_flag && $stable(state_reg.wake_flag))
        else $error("watchdog clear did not set flags");
    AST_SLEEP: assert property (instr.sleep_instr && !rst_evt && state_reg.mode == rsic_pkg::RSIC_RUN
        |=> state_reg.wdt_flag && !state_reg.pd_flag && fetch.sleeping)
        else $error("sleep instruction flags wrong");
    AST_IRQ_VEC: assert property (s_irq_pending ##0 s_quiet
        |=> fetch.vec_req && fetch.vec_addr == rsic_pkg::RSIC_VEC_IRQ && !state_reg.gie ##1 !fetch.vec_req)
        else $error("enabled interrupt did not vector to 008H");
    AST_TRAP_VEC: assert property (instr.trap_instr && state_reg.gie && !rst_evt
        |=> fetch.vec_req && fetch.vec_addr == rsic_pkg::RSIC_VEC_TRAP)
        else $error("trap did not vector to 001H");
    AST_RETURN_FROM_ISR_INSTR: assert property (instr.return_from_isr_instr && !instr.global_irq_off_instr && !rst_evt
        && !instr.trap_instr && !irq_req |=> state_reg.gie)
        else $error("return did not set global enable");
    AST_HOLD: assert property (state_reg.mode == rsic_pkg::RSIC_HOLD |-> fetch.core_reset)
        else $error("core left reset while clear pin low");
    AST_IRQ_AND: assert property (fetch.irq ==
        (|(state_reg.irq_flag_register & state_reg.irq_mask_register)))
        else $error("irq output not the AND of flags and mask");
    AST_CLR_RUN: assert property (clr_fall && state_reg.mode == rsic_pkg::RSIC_RUN
        |=> !state_reg.wake_flag && state_reg.wdt_flag == $past(state_reg.wdt_flag)
        && state_reg.pd_flag == $past(state_reg.pd_flag))
        else $error("clear pin while running disturbed the flags");
    AST_CLR_SLEEP: assert property (clr_fall && state_reg.mode == rsic_pkg::RSIC_SLEEP
        |=> !state_reg.wake_flag && state_reg.wdt_flag && !state_reg.pd_flag && fetch.core_reset)
        else $error("clear pin wake-up flags wrong");
    AST_PORT_WAKE: assert property (s_port_wake ##0 s_quiet
        |=> state_reg.wake_flag && state_reg.wdt_flag && !state_reg.pd_flag && fetch.wake && !fetch.sleeping)
        else $error("port change wake-up flags wrong");
    AST_WAKE_VEC: assert property (s_port_wake ##0 s_quiet ##0 state_reg.gie
        |=> fetch.vec_req && fetch.vec_addr == rsic_pkg::RSIC_VEC_IRQ && !state_reg.gie)
        else $error("wake-up with interrupts on did not vector to 008H");
    AST_WAKE_INLINE: assert property (s_port_wake ##0 s_quiet ##0 !state_reg.gie
        |=> fetch.wake && !fetch.vec_req)
        else $error("wake-up with interrupts off did not continue in line");

endmodule

/* dv/rsic_seq_model.sv */
// Purpose: instruction sequencer and fetch unit facing the block
// Assumes: strobes last one core_clk cycle
// Notes: counts vector requests and wake pulses for the bench
`timescale 1ns/1ps
module rsic_seq_model (
    // clock
    input wire logic core_clk,
    // fetch steering from the block
    input wire rsic_pkg::rsic_fetch_s fetch,
    // strobes to the block
    output rsic_pkg::rsic_instr_s instr
);
    int vec_cnt = 0;
    int wake_cnt = 0;
    logic [11:0] last_vec = 12'h000;
    initial instr = '0;
    // one strobe, raised after an edge and dropped at the next
    task automatic issue(input logic [5:0] v);
        @(posedge core_clk);
        instr <= rsic_pkg::rsic_instr_s'(v);
        @(posedge core_clk);
        instr <= '0;
    endtask
    // pulses stand one cycle, so look at every edge
    always @(posedge core_clk) begin
        if (fetch.vec_req === 1'b1) begin
            vec_cnt <= vec_cnt + 1;
            last_vec <= fetch.vec_addr;
        end
        if (fetch.wake === 1'b1) begin
            wake_cnt <= wake_cnt + 1;
        end
    end
endmodule

/* dv/rsic_tb.sv */
// Purpose: self-checking bench for the reset status and interrupt controller
// Assumes: zero-wait bus slave, pins seen 3-4 edges after they move
// Notes: scenarios run in sequence, each leaves a known status word
`timescale 1ns/1ps
module reset_status_and_interrupt_ctrl_tb_top;
    logic core_clk, nrst, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic hreadyout, hresp, clear_n_pin, timer_counter_ovf, wdt_timeout;
    logic [7:0] port6_pins, port6_is_input;
    rsic_pkg::rsic_instr_s instr;
    rsic_pkg::rsic_fetch_s fetch;
    int miscompares = 0, check_count = 0;
    rsic_top i_dut (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .clear_n_pin(clear_n_pin), .port6_pins(port6_pins),
        .port6_is_input(port6_is_input), .timer_counter_ovf(timer_counter_ovf),
        .wdt_timeout(wdt_timeout), .instr(instr), .fetch(fetch));
    rsic_seq_model i_seq (.core_clk(core_clk), .fetch(fetch), .instr(instr));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // single transfer; address held until hready, data until hready again
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= rsic_pkg::RSIC_HTRANS_NONSEQ;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        r = hrdata;
        hsel <= 1'b0;
        chk(hresp, 32'h0);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic st(input logic [31:0] e);
        rd(rsic_pkg::RSIC_OFS_STATUS, e);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pulse_ovf;
        @(posedge core_clk) timer_counter_ovf <= 1'b1;
        @(posedge core_clk) timer_counter_ovf <= 1'b0;
    endtask
    task automatic pulse_wdt;
        @(posedge core_clk) wdt_timeout <= 1'b1;
        @(posedge core_clk) wdt_timeout <= 1'b0;
        idle(4);
    endtask
    // clear pin pulse; the pin filter needs several edges each way
    task automatic clr;
        @(posedge core_clk) clear_n_pin <= 1'b0;
        idle(10);
        chk(fetch.core_reset, 32'h1);
        clear_n_pin <= 1'b1;
        idle(10);
        chk(fetch.core_reset, 32'h0);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_por;
        st(32'h18);
        rd(rsic_pkg::RSIC_OFS_FLAG, 32'h0);
        rd(32'h40, 32'h0);
    endtask
    task automatic t_port_wake;
        port6_is_input <= 8'h7E;
        wr(rsic_pkg::RSIC_OFS_MASK, 32'h2);
        rd(rsic_pkg::RSIC_OFS_PORT, 32'hFF);
        i_seq.issue(6'h10);
        st(32'h12);
        port6_pins <= 8'h7F;
        idle(10);
        st(32'h12);
        port6_pins <= 8'h7D;
        idle(10);
        chk(i_seq.wake_cnt, 32'h1);
        chk(i_seq.vec_cnt, 32'h0);
        st(32'h90);
        rd(rsic_pkg::RSIC_OFS_FLAG, 32'h2);
        i_seq.issue(6'h20);
        st(32'h98);
    endtask
    task automatic t_clear_run;
        clr();
        st(32'h18);
    endtask
    task automatic t_ext;
        wr(rsic_pkg::RSIC_OFS_CTRL, 32'h1);
        port6_pins <= 8'h7C;
        idle(10);
        rd(rsic_pkg::RSIC_OFS_FLAG, 32'h4);
        wr(rsic_pkg::RSIC_OFS_FLAG, 32'h0);
    endtask
    task automatic t_timer;
        pulse_ovf();
        rd(rsic_pkg::RSIC_OFS_FLAG, 32'h1);
        chk(fetch.irq, 32'h0);
        wr(rsic_pkg::RSIC_OFS_FLAG, 32'h0);
        wr(rsic_pkg::RSIC_OFS_MASK, 32'h1);
        i_seq.issue(6'h08);
        i_seq.issue(6'h04);
        st(32'h18);
        i_seq.issue(6'h08);
        pulse_ovf();
        idle(4);
        chk(fetch.irq, 32'h1);
        chk(i_seq.vec_cnt, 32'h1);
        chk(i_seq.last_vec, 32'h008);
        st(32'h18);
        wr(rsic_pkg::RSIC_OFS_FLAG, 32'h0);
        i_seq.issue(6'h02);
        st(32'h19);
        i_seq.issue(6'h01);
        idle(4);
        chk(i_seq.last_vec, 32'h001);
        chk(i_seq.vec_cnt, 32'h2);
    endtask
    task automatic t_wdt;
        pulse_wdt();
        st(32'h08);
        i_seq.issue(6'h10);
        pulse_wdt();
        st(32'h00);
        i_seq.issue(6'h10);
        clr();
        st(32'h10);
    endtask
    // port wake with interrupts on must vector, not run in line
    task automatic t_wake_vec;
        rd(rsic_pkg::RSIC_OFS_PORT, 32'h7C);
        wr(rsic_pkg::RSIC_OFS_MASK, 32'h2);
        i_seq.issue(6'h08);
        i_seq.issue(6'h10);
        port6_pins <= 8'h7E;
        idle(10);
        chk(i_seq.vec_cnt, 32'h3);
        chk(i_seq.last_vec, 32'h008);
        st(32'h90);
    endtask
    // second power-on reset with non-reset flags and mask in place
    task automatic t_rst_again;
        @(posedge core_clk) nrst <= 1'b0;
        idle(2);
        nrst <= 1'b1;
        st(32'h18);
        rd(rsic_pkg::RSIC_OFS_MASK, 32'h0);
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        nrst <= 1'b0;
        hsel <= 1'b0;
        hwrite <= 1'b0;
        haddr <= 32'h0;
        hwdata <= 32'h0;
        htrans <= 2'h0;
        hsize <= 3'h2;
        clear_n_pin <= 1'b1;
        timer_counter_ovf <= 1'b0;
        wdt_timeout <= 1'b0;
        port6_pins <= 8'hFF;
        port6_is_input <= 8'h00;
        idle(2);
        nrst <= 1'b1;
        t_por();
        t_port_wake();
        t_clear_run();
        t_ext();
        t_timer();
        t_wdt();
        t_wake_vec();
        t_rst_again();
        finish_test();
    end
    // far longer than the sequence needs
    initial begin
        #50000;
        miscompares++;
        finish_test();
    end
endmodule
